// *** hdl/ubw_pkg.sv ***
`default_nettype none
package ubw_pkg;
  // Register word offsets (word addresses on the Avalon-MM slave).
  localparam logic [3:0] ADDR_BAUD_CONTROL     = 4'h0;
  localparam logic [3:0] ADDR_RECEIVE_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_DIVISOR_LOW      = 4'h2;
  localparam logic [3:0] ADDR_DIVISOR_HIGH     = 4'h3;
  localparam logic [3:0] ADDR_TRANSMIT_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_RECEIVE_BUFFER   = 4'h5;
  localparam logic [3:0] ADDR_EVENT_STATUS     = 4'h6;
  localparam int         ADDR_W                = 4;
  // Baud control bit positions.
  localparam int BIT_AB_OVF   = 7;
  localparam int BIT_RX_IDLE  = 6;
  localparam int BIT_WIDE     = 3;
  localparam int BIT_WAKE_EN  = 1;
  localparam int BIT_AB_EN    = 0;
  // Receive status control and transmit status control bit positions.
  localparam int BIT_PORT_EN  = 7;
  localparam int BIT_SYNC     = 4;
  localparam int BIT_HSPEED   = 2;
  // Event status bit positions.
  localparam int BIT_RX_FLAG  = 0;
  localparam int BIT_SLEEPING = 1;
  // Reset values.
  localparam logic [7:0] RST_BAUD_CONTROL  = 8'h40;
  localparam logic [7:0] RST_BYTE          = 8'h00;
  // Prescale factors: Fosc/64 and Fosc/16 asynchronous, Fosc/4 synchronous.
  localparam logic [5:0] PRE_ASYNC_SLOW = 6'h3F;
  localparam logic [5:0] PRE_ASYNC_FAST = 6'h0F;
  localparam logic [5:0] PRE_SYNC       = 6'h03;
  // Rising edges of the sync character that close auto-baud detection.
  localparam logic [2:0] SYNC_RISE_LAST = 3'h5;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
endpackage
`default_nettype wire

// *** hdl/ubw_edge.sv ***
`default_nettype none
module ubw_edge
  import ubw_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Line and edges.
  input  wire logic line_in,
  output logic      fall_pulse,
  output logic      rise_pulse
);
  typedef struct packed {
    logic prev_ff;
  } ubw_edge_state_type;

  ubw_edge_state_type cur_ff;
  ubw_edge_state_type nxt_ff;

  // The idle line is high, so reset assumes high to avoid a false edge.
  always_comb begin
    nxt_ff = cur_ff;
    if (clk_en) begin
      nxt_ff.prev_ff = line_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff.prev_ff <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign fall_pulse = clk_en & cur_ff.prev_ff & ~line_in;
  assign rise_pulse = clk_en & ~cur_ff.prev_ff & line_in;
endmodule
`default_nettype wire

// *** hdl/ubw_brg.sv ***
`default_nettype none
module ubw_brg
  import ubw_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Configuration.
  input  wire logic             run,
  input  wire logic [5:0]       prescale,
  input  wire logic             wide,
  input  wire logic [DIV_W-1:0] divisor,
  // Rate tick.
  output logic                  tick
);
  typedef struct packed {
    logic [5:0]       pre_ff;
    logic [DIV_W-1:0] cnt_ff;
  } ubw_brg_state_type;

  ubw_brg_state_type cur_ff;
  ubw_brg_state_type nxt_ff;
  logic [DIV_W-1:0]  reload;
  logic              pre_done;

  // Narrow mode uses only the low byte of the divisor.
  assign reload   = wide ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]};
  assign pre_done = (cur_ff.pre_ff == 6'h00);

  always_comb begin
    nxt_ff = cur_ff;
    if (clk_en) begin
      if (!run) begin
        nxt_ff.pre_ff = prescale;
        nxt_ff.cnt_ff = reload;
      end else if (pre_done) begin
        nxt_ff.pre_ff = prescale;
        if (cur_ff.cnt_ff == '0) begin
          nxt_ff.cnt_ff = reload;
        end else begin
          nxt_ff.cnt_ff = cur_ff.cnt_ff - 1'b1;
        end
      end else begin
        nxt_ff.pre_ff = cur_ff.pre_ff - 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // One tick every (prescale+1)*(n+1) clocks.
  assign tick = clk_en & run & pre_done & (cur_ff.cnt_ff == '0);

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
    tick |=> !tick) else $error("rate tick repeated on consecutive cycles");
endmodule
`default_nettype wire

// *** hdl/ubw_top.sv ***
`default_nettype none
// Contract
// - Bit rate is Fosc/64(n+1) async slow, Fosc/4(n+1) synchronous.
// - Auto-baud counter passing 16-bit maximum before fifth rise sets overflow flag.
// - Auto-baud overflow also sets the receive-complete flag.
// - After overflow the counter keeps counting until the fifth rise.
// - Receive-idle stays low during auto-baud, rises at the fifth rise.
// - Buffer read after overflow: fifth rise sets receive-complete again.
// - Auto-baud cleared early: remaining falling edges act as start bits.
// - Wake-on-break works only in asynchronous mode.
// - Wake enable suppresses reception and holds receiver idle, watching.
// - A wake event is a falling edge on the receive line.
// - Receive-complete rises at the wake event, awake or asleep.
// - Reading the receive buffer clears the wake-event condition.
// - Rising edge ending the break clears wake enable; receiver then idle.
// - In sleep the baud generator halts; no character is received.
// - Non-zero character under wake: first low time is the wake event.
// - Receive-complete stays set while unread characters remain.
module ubw_top
  import ubw_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // Clock, reset and enable.
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // Avalon-MM slave.
  input  wire logic [ubw_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // Receive line and port status.
  input  wire logic                    receive_data_line,
  input  wire logic                    sleep_mode,
  input  wire logic                    fifo_unread,
  input  wire logic                    char_done,
  input  wire logic [7:0]              fifo_data,
  // Indications to the rest of the port.
  output logic                         receive_complete_flag,
  output logic                         receive_idle_flag,
  output logic                         receive_buffer_read,
  output logic                         start_detect,
  output logic                         rate_tick
);
  import ubw_pkg::*;

  typedef enum {AB_IDLE, AB_WAIT_START, AB_MEASURE} ubw_ab_type;

  typedef struct packed {
    ubw_ab_type       ab_st_ff;
    logic [7:0]       baud_control_ff;
    logic [7:0]       rx_status_ff;
    logic [7:0]       div_low_ff;
    logic [7:0]       div_high_ff;
    logic [7:0]       tx_status_ff;
    logic [2:0]       rise_cnt_ff;
    logic [DIV_W-1:0] ab_cnt_ff;
    logic [2:0]       ab_pre_ff;
    logic             ab_flag_ff;
    logic             wake_flag_ff;
    logic             resume_flag_ff;
    logic             ack_ff;
    logic [31:0]      rdata_ff;
  } ubw_state_type;

  ubw_state_type cur_ff;
  ubw_state_type nxt_ff;
  logic          fall_pulse;
  logic          rise_pulse;
  logic          brg_run;
  logic [5:0]    prescale;
  logic          sync_mode;
  logic          wake_active;
  logic          ab_active;
  logic          access;
  logic          wr_hit;
  logic          rd_buf;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return (a == b);
  endfunction

  ubw_edge u_edge (
    .core_clk   (core_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .line_in    (receive_data_line),
    .fall_pulse (fall_pulse),
    .rise_pulse (rise_pulse)
  );

  assign sync_mode   = cur_ff.tx_status_ff[BIT_SYNC];
  assign wake_active = cur_ff.baud_control_ff[BIT_WAKE_EN] & ~sync_mode;
  assign ab_active   = (cur_ff.ab_st_ff != AB_IDLE);
  // High-speed select is ignored in synchronous mode.
  assign prescale    = sync_mode ? PRE_SYNC :
                       (cur_ff.tx_status_ff[BIT_HSPEED] ? PRE_ASYNC_FAST : PRE_ASYNC_SLOW);
  // Sleep stops the generator; wake and auto-baud do not use it.
  assign brg_run     = cur_ff.rx_status_ff[BIT_PORT_EN] & ~sleep_mode & ~wake_active
                       & ~ab_active;

  ubw_brg #(.DIV_W(DIV_W)) u_brg (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .run      (brg_run),
    .prescale (prescale),
    .wide     (cur_ff.baud_control_ff[BIT_WIDE]),
    .divisor  ({cur_ff.div_high_ff, cur_ff.div_low_ff}),
    .tick     (rate_tick)
  );

  // One wait state: waitrequest drops in the cycle after the request appears.
  assign access          = (avs_read | avs_write) & ~cur_ff.ack_ff & clk_en;
  assign wr_hit          = access & avs_write;
  assign rd_buf          = access & avs_read & hit(avs_address, ADDR_RECEIVE_BUFFER);
  assign avs_waitrequest = (avs_read | avs_write) & ~cur_ff.ack_ff;
  assign avs_readdata    = cur_ff.rdata_ff;

  always_comb begin
    nxt_ff = cur_ff;
    if (clk_en) begin
      nxt_ff.ack_ff = access;
      // Register writes.
      if (wr_hit) begin
        case (avs_address)
          ADDR_BAUD_CONTROL: begin
            // Overflow may only be cleared by software; idle is read-only.
            nxt_ff.baud_control_ff[5:0] = avs_writedata[5:0];
            if (!avs_writedata[BIT_AB_OVF]) begin
              nxt_ff.baud_control_ff[BIT_AB_OVF] = 1'b0;
            end
          end
          ADDR_RECEIVE_STATUS:  nxt_ff.rx_status_ff = avs_writedata[7:0];
          ADDR_DIVISOR_LOW:     nxt_ff.div_low_ff   = avs_writedata[7:0];
          ADDR_DIVISOR_HIGH:    nxt_ff.div_high_ff  = avs_writedata[7:0];
          ADDR_TRANSMIT_STATUS: nxt_ff.tx_status_ff = avs_writedata[7:0];
          default: ;
        endcase
      end
      // Register reads are captured into a flop so data stand with the answer.
      if (access && avs_read) begin
        case (avs_address)
          ADDR_BAUD_CONTROL:    nxt_ff.rdata_ff = {24'h000000, cur_ff.baud_control_ff[7],
                                                   receive_idle_flag,
                                                   cur_ff.baud_control_ff[5:0]};
          ADDR_RECEIVE_STATUS:  nxt_ff.rdata_ff = {24'h000000, cur_ff.rx_status_ff};
          ADDR_DIVISOR_LOW:     nxt_ff.rdata_ff = {24'h000000, cur_ff.div_low_ff};
          ADDR_DIVISOR_HIGH:    nxt_ff.rdata_ff = {24'h000000, cur_ff.div_high_ff};
          ADDR_TRANSMIT_STATUS: nxt_ff.rdata_ff = {24'h000000, cur_ff.tx_status_ff};
          // Wake and auto-baud leave no character, so the buffer reads zero then.
          ADDR_RECEIVE_BUFFER:  nxt_ff.rdata_ff = {24'h000000,
                                                   fifo_unread ? fifo_data : ZERO_BYTE};
          ADDR_EVENT_STATUS:    nxt_ff.rdata_ff = {30'h00000000, sleep_mode,
                                                   receive_complete_flag};
          default:              nxt_ff.rdata_ff = 32'h00000000;
        endcase
      end

      // Buffer read clears event flags; a new event in the same cycle wins.
      if (rd_buf) begin
        nxt_ff.ab_flag_ff     = 1'b0;
        nxt_ff.wake_flag_ff   = 1'b0;
        nxt_ff.resume_flag_ff = 1'b0;
      end

      // Wake-on-break watches for the falling edge, even while asleep.
      if (wake_active && fall_pulse) begin
        nxt_ff.wake_flag_ff = 1'b1;
      end
      if (wake_active && rise_pulse) begin
        nxt_ff.baud_control_ff[BIT_WAKE_EN] = 1'b0;
      end

      // Auto-baud: wait for the start edge, then count to the fifth rise.
      case (cur_ff.ab_st_ff)
        AB_IDLE: begin
          if (cur_ff.baud_control_ff[BIT_AB_EN] && !wake_active) begin
            nxt_ff.ab_st_ff = AB_WAIT_START;
          end
        end
        AB_WAIT_START: begin
          if (fall_pulse) begin
            nxt_ff.ab_st_ff    = AB_MEASURE;
            nxt_ff.rise_cnt_ff = 3'h0;
            nxt_ff.ab_cnt_ff   = '0;
            nxt_ff.ab_pre_ff   = 3'h0;
          end
        end
        AB_MEASURE: begin
          nxt_ff.ab_pre_ff = cur_ff.ab_pre_ff + 3'h1;
          if (cur_ff.ab_pre_ff == 3'h7) begin
            nxt_ff.ab_cnt_ff = cur_ff.ab_cnt_ff + 1'b1;
            if (&cur_ff.ab_cnt_ff) begin
              nxt_ff.baud_control_ff[BIT_AB_OVF] = 1'b1;
              nxt_ff.ab_flag_ff = 1'b1;
            end
          end
          if (rise_pulse) begin
            nxt_ff.rise_cnt_ff = cur_ff.rise_cnt_ff + 3'h1;
            if (cur_ff.rise_cnt_ff + 3'h1 == SYNC_RISE_LAST) begin
              nxt_ff.ab_st_ff = AB_IDLE;
              nxt_ff.baud_control_ff[BIT_AB_EN] = 1'b0;
              if (!cur_ff.baud_control_ff[BIT_AB_OVF]) begin
                {nxt_ff.div_high_ff, nxt_ff.div_low_ff} = 16'(cur_ff.ab_cnt_ff);
              end else begin
                nxt_ff.resume_flag_ff = 1'b1;
              end
            end
          end
        end
        default: nxt_ff.ab_st_ff = AB_IDLE;
      endcase
      // Disabling auto-baud early abandons the measurement.
      if (!cur_ff.baud_control_ff[BIT_AB_EN] && ab_active) begin
        nxt_ff.ab_st_ff = AB_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff                 <= '0;
      cur_ff.ab_st_ff        <= AB_IDLE;
      cur_ff.baud_control_ff <= RST_BAUD_CONTROL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Receive-complete: FIFO content, wake event, overflow or final sync rise after overflow.
  assign receive_complete_flag = fifo_unread | cur_ff.wake_flag_ff | cur_ff.ab_flag_ff
                                 | cur_ff.resume_flag_ff;
  assign receive_idle_flag     = ~ab_active & (wake_active | ~char_done);
  assign receive_buffer_read   = rd_buf;
  // Falling edges become start bits only outside auto-baud and wake.
  assign start_detect          = fall_pulse & ~ab_active & ~wake_active
                                 & ~sleep_mode & cur_ff.rx_status_ff[BIT_PORT_EN];

  a_wake_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wake_active && fall_pulse) |=> receive_complete_flag)
    else $error("wake event did not raise receive-complete");
  a_wake_clears_en: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wake_active && rise_pulse) |=> !cur_ff.baud_control_ff[BIT_WAKE_EN])
    else $error("rising edge did not end wake enable");
  a_idle_low_ab: assert property (@(posedge core_clk) disable iff (rst)
    ab_active |-> !receive_idle_flag) else $error("idle high during auto-baud");
  a_no_start_wake: assert property (@(posedge core_clk) disable iff (rst)
    wake_active |-> !start_detect) else $error("reception not suppressed under wake");
  a_ovf_sets_rc: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cur_ff.baud_control_ff[BIT_AB_OVF]) && ab_active |-> receive_complete_flag)
    else $error("overflow did not raise receive-complete");
  a_sync_no_wake: assert property (@(posedge core_clk) disable iff (rst)
    sync_mode |-> !wake_active) else $error("wake active in synchronous mode");
  a_sleep_no_tick: assert property (@(posedge core_clk) disable iff (rst)
    sleep_mode |-> !rate_tick) else $error("baud tick during sleep");
  a_fifo_holds_rc: assert property (@(posedge core_clk) disable iff (rst)
    fifo_unread |-> receive_complete_flag) else $error("flag low with unread data");

  c_wake_event: cover property (@(posedge core_clk) wake_active && fall_pulse);
  c_ab_overflow: cover property (@(posedge core_clk) $rose(cur_ff.baud_control_ff[BIT_AB_OVF]));
  c_ab_done: cover property (@(posedge core_clk) $fell(ab_active));
endmodule
`default_nettype wire

// *** bench/ubw_line_model.sv ***
`default_nettype none
module ubw_line_model (
  // Clock.
  input  wire logic core_clk,
  // Receive line towards the port.
  output var logic  line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line idles high, as a stop level does, so nothing is left floating.
  initial line_out = 1'b1;
  task automatic hold_level(input logic lvl, input int clks);
    line_out <= lvl;
    repeat (clks) @(posedge core_clk);
  endtask
  // All-zero wake character, then idle long enough for the port to settle.
  task automatic send_break(input int nbits, input int bclk);
    hold_level(1'b0, nbits * bclk);
    hold_level(1'b1, 4 * bclk);
  endtask
  task automatic send_char(input logic [7:0] data, input int bclk);
    hold_level(1'b0, bclk);
    for (int i = 0; i < 8; i++) begin
      hold_level(data[i], bclk);
    end
    hold_level(1'b1, 2 * bclk);
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench;
  import ubw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BCLK = 16;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              line;
  logic              sleep_mode = 1'b0;
  logic              fifo_unread = 1'b0;
  logic              char_done = 1'b0;
  logic [7:0]        fifo_data = 8'hA5;
  logic              receive_complete_flag;
  logic              receive_idle_flag;
  logic              start_detect;
  logic              rate_tick;
  int                error_cnt = 0;
  int                total_checks = 0;
  int                start_cnt = 0;
  int                tick_cnt = 0;
  logic [7:0]        tx_cfg [6] = '{8'h00, 8'h00, 8'h04, 8'h10, 8'h14, 8'h10};
  logic [7:0]        wide_cfg [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  logic [7:0]        hi_cfg [6] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0]        lo_cfg [6] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00};
  int                per_cfg [6] = '{128, 192, 32, 8, 8, 1028};

  always #50 core_clk = ~core_clk;

  ubw_top #(.DIV_W(16)) dut (
    .core_clk              (core_clk),
    .rst                   (rst),
    .clk_en                (1'b1),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .receive_data_line     (line),
    .sleep_mode            (sleep_mode),
    .fifo_unread           (fifo_unread),
    .char_done             (char_done),
    .fifo_data             (fifo_data),
    .receive_complete_flag (receive_complete_flag),
    .receive_idle_flag     (receive_idle_flag),
    .receive_buffer_read   (),
    .start_detect          (start_detect),
    .rate_tick             (rate_tick)
  );

  ubw_line_model remote (
    .core_clk (core_clk),
    .line_out (line)
  );

  always @(posedge core_clk) begin
    if (start_detect === 1'b1) begin
      start_cnt++;
    end
    if (rate_tick === 1'b1) begin
      tick_cnt++;
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // An idle edge first, so a new request never lands in the step of the last release.
  task automatic bus_access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                            output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    check(n < 50, 1'b1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] unused;
    bus_access(1'b1, a, d, unused);
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus_access(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask

  task automatic wait_rc(input logic lvl, input int lim);
    int n;
    n = 0;
    while (receive_complete_flag !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, receive_complete_flag}, {31'h0, lvl});
  endtask

  task automatic tick_period(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rate_tick !== 1'b1 && n < 5000);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rate_tick !== 1'b1 && n < 5000);
    check(n, exp);
  endtask

  initial begin
    #(20000 * 100);
    error_cnt++;
    $display("Error at %0t: watchdog got %0h expected %0h", $time, 0, 1);
    complete_run();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    reg_chk(ADDR_BAUD_CONTROL, {24'h0, RST_BAUD_CONTROL});
    for (int a = 1; a < 5; a++) begin
      reg_chk(a[3:0], 32'h0);
    end
    reg_wr(4'h9, 8'hFF);
    reg_chk(4'h9, 32'h0);
    $display("Done: reset values and unmapped access");
    reg_wr(ADDR_RECEIVE_STATUS, 8'h80);
    for (int i = 0; i < 6; i++) begin
      reg_wr(ADDR_TRANSMIT_STATUS, tx_cfg[i]);
      reg_wr(ADDR_BAUD_CONTROL, wide_cfg[i]);
      reg_wr(ADDR_DIVISOR_HIGH, hi_cfg[i]);
      reg_wr(ADDR_DIVISOR_LOW, lo_cfg[i]);
      tick_period(per_cfg[i]);
    end
    sleep_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    tick_cnt = 0;
    repeat (100) @(posedge core_clk);
    check(tick_cnt, 0);
    sleep_mode <= 1'b0;
    $display("Done: baud generator rates and sleep halt");
    reg_wr(ADDR_TRANSMIT_STATUS, 8'h00);
    reg_wr(ADDR_BAUD_CONTROL, 8'h00);
    reg_chk(ADDR_BAUD_CONTROL, 32'h40);
    reg_wr(ADDR_BAUD_CONTROL, 8'h02);
    sleep_mode <= 1'b1;
    start_cnt = 0;
    fork
      remote.send_break(13, BCLK);
      begin
        wait_rc(1'b1, 4);
        check({31'h0, receive_idle_flag}, 32'h1);
      end
    join
    check(start_cnt, 0);
    sleep_mode <= 1'b0;
    reg_chk(ADDR_BAUD_CONTROL, 32'h40);
    reg_chk(ADDR_RECEIVE_BUFFER, 32'h00);
    wait_rc(1'b0, 2);
    reg_wr(ADDR_BAUD_CONTROL, 8'h02);
    remote.send_char(8'h3C, BCLK);
    check({31'h0, receive_complete_flag}, 32'h1);
    reg_chk(ADDR_BAUD_CONTROL, 32'h40);
    reg_chk(ADDR_RECEIVE_BUFFER, 32'h00);
    $display("Done: wake on break");
    reg_wr(ADDR_TRANSMIT_STATUS, 8'h10);
    reg_wr(ADDR_BAUD_CONTROL, 8'h02);
    remote.send_break(13, BCLK);
    check({31'h0, receive_complete_flag}, 32'h0);
    fifo_unread <= 1'b1;
    wait_rc(1'b1, 2);
    reg_chk(ADDR_RECEIVE_BUFFER, 32'hA5);
    fifo_unread <= 1'b0;
    wait_rc(1'b0, 2);
    $display("Done: synchronous mode and unread data");
    reg_wr(ADDR_TRANSMIT_STATUS, 8'h00);
    reg_wr(ADDR_BAUD_CONTROL, 8'h00);
    char_done <= 1'b1;
    repeat (2) @(posedge core_clk);
    check({31'h0, receive_idle_flag}, 32'h0);
    char_done <= 1'b0;
    reg_wr(ADDR_BAUD_CONTROL, 8'h01);
    fork
      remote.send_char(8'h55, BCLK);
      begin
        repeat (3 * BCLK) @(posedge core_clk);
        check({31'h0, receive_idle_flag}, 32'h0);
      end
    join
    reg_chk(ADDR_BAUD_CONTROL, 32'h40);
    // Software clearing sequence: read the buffer, confirm idle, then clear overflow.
    reg_chk(ADDR_RECEIVE_BUFFER, 32'h00);
    check({31'h0, receive_idle_flag}, 32'h1);
    reg_wr(ADDR_BAUD_CONTROL, 8'h00);
    reg_chk(ADDR_BAUD_CONTROL, 32'h40);
    reg_wr(ADDR_BAUD_CONTROL, 8'h01);
    start_cnt = 0;
    fork
      remote.send_char(8'h55, BCLK);
      begin
        repeat (2 * BCLK) @(posedge core_clk);
        reg_wr(ADDR_BAUD_CONTROL, 8'h00);
      end
    join
    check(start_cnt >= 2, 1'b1);
    $display("Done: auto-baud detection");
    complete_run();
  end
endmodule
`default_nettype wire
